// ### common/esr_pkg.sv
// Shared constants, register map and types of the engine speed reference sequencer.
package esr_pkg;
	localparam int CLK_MHZ = 50;
	localparam int TICK_PERIOD_US = 1000;
	localparam int TICK_CYCLES_DFLT = TICK_PERIOD_US * CLK_MHZ;

	localparam logic [5:0] OFF_CTRL = 6'h00;
	localparam logic [5:0] OFF_STATUS = 6'h04;
	localparam logic [5:0] OFF_IDLE = 6'h08;
	localparam logic [5:0] OFF_RATED = 6'h0c;
	localparam logic [5:0] OFF_LOWER_LIM = 6'h10;
	localparam logic [5:0] OFF_RAISE_LIM = 6'h14;
	localparam logic [5:0] OFF_REM_LO = 6'h18;
	localparam logic [5:0] OFF_REM_HI = 6'h1c;
	localparam logic [5:0] OFF_ACCEL_T = 6'h20;
	localparam logic [5:0] OFF_DECEL_T = 6'h24;
	localparam logic [5:0] OFF_RAISE_RATE = 6'h28;
	localparam logic [5:0] OFF_LOWER_RATE = 6'h2c;
	localparam logic [5:0] OFF_TORS_LIM = 6'h30;
	localparam logic [5:0] OFF_TORS_FUEL = 6'h34;
	localparam logic [5:0] OFF_SPEED_REF = 6'h38;

	localparam int CTRL_TORS_EN_BIT = 0;
	localparam int CTRL_START_AR_BIT = 1;
	localparam int CTRL_AR_CMD_BIT = 2;

	localparam logic [15:0] RST_IDLE = 16'h02bc;
	localparam logic [15:0] RST_RATED = 16'h0708;
	localparam logic [15:0] RST_LOWER_LIM = 16'h0640;
	localparam logic [15:0] RST_RAISE_LIM = 16'h076c;
	localparam logic [15:0] RST_REM_LO = 16'h0640;
	localparam logic [15:0] RST_REM_HI = 16'h076c;
	localparam logic [15:0] RST_ACCEL_T = 16'h2710;
	localparam logic [15:0] RST_DECEL_T = 16'h2710;
	localparam logic [15:0] RST_RAISE_RATE = 16'h0001;
	localparam logic [15:0] RST_LOWER_RATE = 16'h0001;
	localparam logic [15:0] RST_TORS_LIM = 16'hffff;
	localparam logic [15:0] RST_TORS_FUEL = 16'h2710;

	localparam logic [15:0] REM_FAIL_CODE = 16'h0800;
	localparam logic [15:0] REM_LOW_CODE = 16'h1000;
	localparam logic [15:0] REM_HIGH_CODE = 16'h5000;
	localparam int REM_SPAN_LOG2 = 14;
	localparam logic [15:0] FUEL_MAX = 16'h2710;
	localparam logic [20:0] FAIL_DIV = 21'h000014;

	typedef enum logic [1:0] {
		ESR_IDLE = 2'b00,
		ESR_ACCEL = 2'b01,
		ESR_RATED = 2'b10,
		ESR_DECEL = 2'b11
	} esr_mode_t;

	typedef struct packed {
		logic rated;
		logic raise;
		logic lower;
		logic alarm_reset;
		logic fail_ovrd;
		logic alt_gain;
	} esr_contacts_t;

	typedef struct packed {
		logic tors_en;
		logic start_ar_en;
		logic [15:0] idle;
		logic [15:0] rated;
		logic [15:0] lower_lim;
		logic [15:0] raise_lim;
		logic [15:0] rem_lo;
		logic [15:0] rem_hi;
		logic [15:0] accel_t;
		logic [15:0] decel_t;
		logic [15:0] raise_rate;
		logic [15:0] lower_rate;
		logic [15:0] tors_lim;
		logic [15:0] tors_fuel;
	} esr_cfg_t;

	typedef struct packed {
		esr_contacts_t sync1;
		esr_contacts_t sync2;
		esr_cfg_t cfg;
		esr_mode_t st;
		logic ar_prev;
		logic por;
		logic anyok_prev;
		logic ar_pulse;
		logic fail_a;
		logic fail_b;
		logic rem_fail;
		logic tors_hi;
		logic ack;
		logic [31:0] rdata;
		logic [31:0] tick_cnt;
		logic [31:0] acc;
		logic [15:0] ref_spd;
		logic [15:0] sel;
		logic [15:0] fuel;
		logic signed [16:0] err;
	} esr_state_t;
endpackage

// ### design/esr_seq.sv
// Speed selection, failure handling, alarm reset and speed reference sequencing with Avalon-MM registers.
module esr_seq #(
	parameter int unsigned TICK_CYCLES = esr_pkg::TICK_CYCLES_DFLT
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire esr_pkg::esr_contacts_t contacts_i,
	input wire logic [15:0] spd_a_i,
	input wire logic [15:0] spd_b_i,
	input wire logic [15:0] spd_filt_i,
	input wire logic [15:0] tors_level_i,
	input wire logic [15:0] rem_code_i,
	input wire logic [15:0] pid_fuel_i,
	input wire logic [15:0] max_fuel_i,
	input wire logic [15:0] start_fuel_i,
	output logic [15:0] speed_ref_o,
	output logic [15:0] speed_sel_o,
	output logic signed [16:0] speed_err_o,
	output logic [15:0] fuel_demand_o,
	output logic alternate_gain_set_select_o,
	output logic alarm_reset_pulse_o,
	output logic [1:0] sensor_fail_o,
	output logic remote_fail_o,
	output logic tors_limit_o,
	output logic remote_sel_o
);
	import esr_pkg::*;

	esr_state_t r;
	esr_state_t n;
	esr_contacts_t c;
	logic fail_a_now;
	logic fail_b_now;
	logic both_fail;
	logic tors_act;
	logic tors_hi_now;
	logic rem_fail_now;
	logic remote;
	logic one_cmd;
	logic tick;
	logic ar;
	logic wr_ok;
	logic [15:0] hs;
	logic [15:0] idle_eff;
	logic [15:0] delta;
	logic [15:0] xc;
	logic [15:0] xoff;
	logic signed [16:0] span;
	logic signed [33:0] prod;
	logic signed [33:0] tsum;
	logic [15:0] rem_raw;
	logic [15:0] rem_tgt;
	logic [15:0] pid_t;
	logic [15:0] fuel_c;
	logic [31:0] acc1;
	logic [31:0] rd;

	function automatic logic [15:0] step_to(input logic [15:0] cur, input logic [15:0] tgt,
		input logic [15:0] up, input logic [15:0] dn);
		logic [16:0] s;
		s = {1'b0, cur} + {1'b0, up};
		if (cur < tgt) begin
			step_to = (s > {1'b0, tgt}) ? tgt : s[15:0];
		end else begin
			step_to = ((cur - tgt) < dn) ? tgt : cur - dn;
		end
	endfunction

	function automatic logic low_speed(input logic [15:0] s, input logic [15:0] rated);
		low_speed = (({5'h00, s} * FAIL_DIV) < {5'h00, rated});
	endfunction

	function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
		min16 = (a < b) ? a : b;
	endfunction

	always_comb begin
		n = r;
		n.sync1 = contacts_i;
		n.sync2 = r.sync1;
		c = r.sync2;
		remote = c.raise & c.lower;
		one_cmd = c.raise ^ c.lower;
		fail_a_now = low_speed(spd_a_i, r.cfg.rated);
		fail_b_now = low_speed(spd_b_i, r.cfg.rated);
		both_fail = fail_a_now & fail_b_now;
		tors_act = r.cfg.tors_en & ~fail_a_now & ~fail_b_now;
		hs = (spd_a_i > spd_b_i) ? spd_a_i : spd_b_i;
		n.sel = tors_act ? spd_filt_i : hs;
		tors_hi_now = tors_act & (tors_level_i >= r.cfg.tors_lim);
		rem_fail_now = rem_code_i < REM_FAIL_CODE;
		// A fixed tick of TICK_CYCLES clocks keeps ramp slopes independent of bus traffic; its period scales with the clock period.
		tick = (r.tick_cnt == 32'(TICK_CYCLES - 1));
		n.tick_cnt = tick ? 32'h0 : r.tick_cnt + 32'h1;
		wr_ok = avs_write_i & r.ack;
		n.ar_prev = c.alarm_reset;
		n.anyok_prev = ~both_fail;
		n.por = 1'b0;
		ar = r.por
			| (r.ar_prev & ~c.alarm_reset)
			| (r.cfg.start_ar_en & ~both_fail & ~r.anyok_prev)
			| (wr_ok & (avs_address_i[5:2] == OFF_CTRL[5:2]) & avs_writedata_i[CTRL_AR_CMD_BIT]);
		n.ar_pulse = ar;
		// A fresh failure in the reset cycle keeps its flag set.
		n.fail_a = fail_a_now | (r.fail_a & ~ar);
		n.fail_b = fail_b_now | (r.fail_b & ~ar);
		n.rem_fail = rem_fail_now | (r.rem_fail & ~ar);
		n.tors_hi = tors_hi_now | (r.tors_hi & ~ar);
		xc = (rem_code_i < REM_LOW_CODE) ? REM_LOW_CODE :
			((rem_code_i > REM_HIGH_CODE) ? REM_HIGH_CODE : rem_code_i);
		xoff = xc - REM_LOW_CODE;
		span = $signed({1'b0, r.cfg.rem_hi}) - $signed({1'b0, r.cfg.rem_lo});
		prod = span * $signed({1'b0, xoff});
		tsum = $signed({18'h00000, r.cfg.rem_lo}) + (prod >>> REM_SPAN_LOG2);
		rem_raw = tsum[15:0];
		if (rem_fail_now) begin
			rem_tgt = r.cfg.lower_lim;
		end else if (rem_raw > r.cfg.raise_lim) begin
			rem_tgt = r.cfg.raise_lim;
		end else if (rem_raw < r.cfg.lower_lim) begin
			rem_tgt = r.cfg.lower_lim;
		end else begin
			rem_tgt = rem_raw;
		end
		idle_eff = (r.cfg.idle > r.cfg.rated) ? r.cfg.rated : r.cfg.idle;
		delta = r.cfg.rated - idle_eff;
		acc1 = r.acc + (tick ? {16'h0000, delta} : 32'h0);
		case (r.st)
			ESR_IDLE: begin
				n.ref_spd = idle_eff;
				n.acc = 32'h0;
				if (c.rated) begin
					n.st = ESR_ACCEL;
				end
			end
			ESR_ACCEL: begin
				if (!c.rated) begin
					n.st = ESR_DECEL;
					n.acc = 32'h0;
				end else if (remote) begin
					if (tick) begin
						n.ref_spd = step_to(r.ref_spd, rem_tgt, r.cfg.raise_rate, r.cfg.raise_rate);
					end
					if (r.ref_spd == rem_tgt) begin
						n.st = ESR_RATED;
					end
				end else if (one_cmd) begin
					n.st = ESR_RATED;
				end else if ((r.ref_spd >= r.cfg.rated) || (r.cfg.accel_t == 16'h0000)) begin
					n.ref_spd = r.cfg.rated;
					n.st = ESR_RATED;
				end else if (acc1 >= {16'h0000, r.cfg.accel_t}) begin
					// One unit per clock keeps the slope exact as long as delta stays below the tick length.
					n.ref_spd = r.ref_spd + 16'h0001;
					n.acc = acc1 - {16'h0000, r.cfg.accel_t};
				end else begin
					n.acc = acc1;
				end
			end
			ESR_RATED: begin
				n.acc = 32'h0;
				if (!c.rated) begin
					n.st = ESR_DECEL;
				end else if (tick && remote) begin
					n.ref_spd = step_to(r.ref_spd, rem_tgt, r.cfg.raise_rate, r.cfg.lower_rate);
				end else if (tick && c.raise && !c.lower) begin
					n.ref_spd = step_to(r.ref_spd, r.cfg.raise_lim, r.cfg.raise_rate, r.cfg.raise_rate);
				end else if (tick && c.lower && !c.raise) begin
					n.ref_spd = step_to(r.ref_spd, r.cfg.lower_lim, r.cfg.lower_rate, r.cfg.lower_rate);
				end
			end
			ESR_DECEL: begin
				if (c.rated) begin
					n.st = ESR_ACCEL;
					n.acc = 32'h0;
				end else if ((r.ref_spd <= idle_eff) || (r.cfg.decel_t == 16'h0000)) begin
					n.ref_spd = idle_eff;
					n.st = ESR_IDLE;
				end else if (acc1 >= {16'h0000, r.cfg.decel_t}) begin
					n.ref_spd = r.ref_spd - 16'h0001;
					n.acc = acc1 - {16'h0000, r.cfg.decel_t};
				end else begin
					n.acc = acc1;
				end
			end
			default: begin
				n.st = ESR_IDLE;
			end
		endcase
		if (both_fail) begin
			pid_t = c.fail_ovrd ? FUEL_MAX : 16'h0000;
		end else begin
			pid_t = pid_fuel_i;
		end
		fuel_c = min16(min16(pid_t, max_fuel_i), min16(start_fuel_i, tors_hi_now ? r.cfg.tors_fuel : FUEL_MAX));
		n.fuel = (both_fail && !c.fail_ovrd) ? 16'h0000 : fuel_c;
		n.err = $signed({1'b0, r.ref_spd}) - $signed({1'b0, r.sel});
		case (avs_address_i[5:2])
			OFF_CTRL[5:2]: rd = {30'h0, r.cfg.start_ar_en, r.cfg.tors_en};
			OFF_STATUS[5:2]: rd = {22'h0, r.st, c.alt_gain, remote, r.tors_hi, r.rem_fail,
				both_fail, tors_act, r.fail_b, r.fail_a};
			OFF_IDLE[5:2]: rd = {16'h0, r.cfg.idle};
			OFF_RATED[5:2]: rd = {16'h0, r.cfg.rated};
			OFF_LOWER_LIM[5:2]: rd = {16'h0, r.cfg.lower_lim};
			OFF_RAISE_LIM[5:2]: rd = {16'h0, r.cfg.raise_lim};
			OFF_REM_LO[5:2]: rd = {16'h0, r.cfg.rem_lo};
			OFF_REM_HI[5:2]: rd = {16'h0, r.cfg.rem_hi};
			OFF_ACCEL_T[5:2]: rd = {16'h0, r.cfg.accel_t};
			OFF_DECEL_T[5:2]: rd = {16'h0, r.cfg.decel_t};
			OFF_RAISE_RATE[5:2]: rd = {16'h0, r.cfg.raise_rate};
			OFF_LOWER_RATE[5:2]: rd = {16'h0, r.cfg.lower_rate};
			OFF_TORS_LIM[5:2]: rd = {16'h0, r.cfg.tors_lim};
			OFF_TORS_FUEL[5:2]: rd = {16'h0, r.cfg.tors_fuel};
			OFF_SPEED_REF[5:2]: rd = {16'h0, r.ref_spd};
			default: rd = 32'h0;
		endcase
		// One wait state on every access keeps read data in a flip-flop.
		n.ack = (avs_read_i | avs_write_i) & ~r.ack;
		if (avs_read_i && !r.ack) begin
			n.rdata = rd;
		end
		if (wr_ok) begin
			case (avs_address_i[5:2])
				OFF_CTRL[5:2]: begin
					n.cfg.tors_en = avs_writedata_i[CTRL_TORS_EN_BIT];
					n.cfg.start_ar_en = avs_writedata_i[CTRL_START_AR_BIT];
				end
				OFF_IDLE[5:2]: n.cfg.idle = avs_writedata_i[15:0];
				OFF_RATED[5:2]: n.cfg.rated = avs_writedata_i[15:0];
				OFF_LOWER_LIM[5:2]: n.cfg.lower_lim = avs_writedata_i[15:0];
				OFF_RAISE_LIM[5:2]: n.cfg.raise_lim = avs_writedata_i[15:0];
				OFF_REM_LO[5:2]: n.cfg.rem_lo = avs_writedata_i[15:0];
				OFF_REM_HI[5:2]: n.cfg.rem_hi = avs_writedata_i[15:0];
				OFF_ACCEL_T[5:2]: n.cfg.accel_t = avs_writedata_i[15:0];
				OFF_DECEL_T[5:2]: n.cfg.decel_t = avs_writedata_i[15:0];
				OFF_RAISE_RATE[5:2]: n.cfg.raise_rate = avs_writedata_i[15:0];
				OFF_LOWER_RATE[5:2]: n.cfg.lower_rate = avs_writedata_i[15:0];
				OFF_TORS_LIM[5:2]: n.cfg.tors_lim = avs_writedata_i[15:0];
				OFF_TORS_FUEL[5:2]: n.cfg.tors_fuel = avs_writedata_i[15:0];
				default: n.cfg = r.cfg;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
			r.por <= 1'b1;
			r.st <= ESR_IDLE;
			r.cfg.idle <= RST_IDLE;
			r.cfg.rated <= RST_RATED;
			r.cfg.lower_lim <= RST_LOWER_LIM;
			r.cfg.raise_lim <= RST_RAISE_LIM;
			r.cfg.rem_lo <= RST_REM_LO;
			r.cfg.rem_hi <= RST_REM_HI;
			r.cfg.accel_t <= RST_ACCEL_T;
			r.cfg.decel_t <= RST_DECEL_T;
			r.cfg.raise_rate <= RST_RAISE_RATE;
			r.cfg.lower_rate <= RST_LOWER_RATE;
			r.cfg.tors_lim <= RST_TORS_LIM;
			r.cfg.tors_fuel <= RST_TORS_FUEL;
		end else begin
			r <= n;
		end
	end

	assign avs_readdata_o = r.rdata;
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~r.ack;
	assign speed_ref_o = r.ref_spd;
	assign speed_sel_o = r.sel;
	assign speed_err_o = r.err;
	assign fuel_demand_o = r.fuel;
	assign alternate_gain_set_select_o = r.sync2.alt_gain;
	assign alarm_reset_pulse_o = r.ar_pulse;
	assign sensor_fail_o = {r.fail_b, r.fail_a};
	assign remote_fail_o = r.rem_fail;
	assign tors_limit_o = r.tors_hi;
	assign remote_sel_o = r.sync2.raise & r.sync2.lower;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_hss_select: assert property (!tors_act |=> speed_sel_o == $past(hs)) else $error("high select lost");
	a_fail_revert: assert property ((fail_a_now || fail_b_now) |-> !tors_act) else $error("filter kept on fail");
	a_tors_limit: assert property (tors_hi_now |=> fuel_demand_o <= $past(r.cfg.tors_fuel)) else $error("tors limit");
	a_fail_flag: assert property (fail_a_now |=> sensor_fail_o[0]) else $error("sensor fail not flagged");
	a_zero_fuel: assert property (both_fail && !c.fail_ovrd |=> fuel_demand_o == 16'h0000) else $error("fuel not zero");
	a_reset_clears: assert property (ar && !fail_a_now |=> !sensor_fail_o[0]) else $error("flag not cleared");
	a_contact_pulse: assert property (r.ar_prev && !c.alarm_reset |=> alarm_reset_pulse_o) else $error("no contact reset");
	a_por_pulse: assert property (r.por |=> alarm_reset_pulse_o ##1 !r.por) else $error("no power-up reset");
	a_rated_start: assert property (r.st == ESR_IDLE && c.rated |=> r.st == ESR_ACCEL) else $error("no accel");
	a_accel_abort: assert property (r.st == ESR_ACCEL && c.rated && one_cmd |=> r.st == ESR_RATED) else $error("no abort");
	a_decel_start: assert property (r.st == ESR_RATED && !c.rated |=> r.st == ESR_DECEL) else $error("no decel");
	a_idle_cap: assert property (r.st == ESR_IDLE && $past(r.st == ESR_IDLE) |-> r.ref_spd <= r.cfg.rated)
		else $error("idle above rated");
	a_bus_wait: assert property ((avs_read_i || avs_write_i) && !r.ack |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("bus answer late");

	c_accel_done: cover property (r.st == ESR_ACCEL ##1 r.st == ESR_RATED);
	c_remote_rated: cover property (r.st == ESR_RATED && remote && tick);
	c_both_fail: cover property (both_fail && c.fail_ovrd);
	c_decel_idle: cover property (r.st == ESR_DECEL ##1 r.st == ESR_IDLE);
endmodule // esr_seq

// ### bench/esr_far_side.sv
// Behavioural model of the speed sensors, operator contacts and remote reference.
module esr_far_side (
	input wire logic sys_clk_i,
	output esr_pkg::esr_contacts_t contacts_o,
	output logic [15:0] spd_a_o,
	output logic [15:0] spd_b_o,
	output logic [15:0] spd_filt_o,
	output logic [15:0] tors_level_o,
	output logic [15:0] rem_code_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import esr_pkg::*;

	// Both sensors start healthy so that the power-up reset finds nothing to clear.
	initial begin
		contacts_o = '0;
		spd_a_o = 16'h03e8;
		spd_b_o = 16'h04b0;
		spd_filt_o = 16'h05dc;
		tors_level_o = 16'h0000;
		rem_code_o = 16'h3000;
	end

	task automatic set_spd(input logic [15:0] a, input logic [15:0] b);
		@(posedge sys_clk_i);
		spd_a_o <= a;
		spd_b_o <= b;
	endtask

	task automatic set_ct(input esr_contacts_t c);
		@(posedge sys_clk_i);
		contacts_o <= c;
	endtask

	task automatic set_rem(input logic [15:0] c);
		@(posedge sys_clk_i);
		rem_code_o <= c;
	endtask

	task automatic set_filt(input logic [15:0] f);
		@(posedge sys_clk_i);
		spd_filt_o <= f;
	endtask

	task automatic set_tors(input logic [15:0] l);
		@(posedge sys_clk_i);
		tors_level_o <= l;
	endtask

	// The contact is held long enough to pass the input synchroniser before it opens again.
	task automatic alarm_toggle;
		@(posedge sys_clk_i);
		contacts_o.alarm_reset <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		contacts_o.alarm_reset <= 1'b0;
	endtask
endmodule // esr_far_side

// ### bench/esr_seq_bench.sv
// Self-checking testbench of the engine speed reference sequencer.
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin num_errors++; $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module esr_seq_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import esr_pkg::*;
	// A short tick keeps every ramp within a few hundred cycles.
	localparam int TC = 16;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] adr = 6'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [15:0] pid_fuel = 16'h1000;
	logic [15:0] max_fuel = 16'h2000;
	logic [15:0] start_fuel = 16'h2710;
	logic [31:0] rdat;
	logic wait_req;
	esr_contacts_t ct;
	logic [15:0] spd_a, spd_b, spd_filt, tors, rem, sref, ssel, fuel;
	logic signed [16:0] serr;
	logic alt, arp, rfail, tlim, rsel;
	logic [1:0] sfail;
	int num_errors = 0;
	int tests_run = 0;
	int n;
	logic [31:0] rv;

	always #10 sys_clk = ~sys_clk;

	esr_far_side far (.sys_clk_i(sys_clk), .contacts_o(ct), .spd_a_o(spd_a), .spd_b_o(spd_b),
		.spd_filt_o(spd_filt), .tors_level_o(tors), .rem_code_o(rem));

	esr_seq #(.TICK_CYCLES(TC)) DUT (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wait_req), .contacts_i(ct), .spd_a_i(spd_a), .spd_b_i(spd_b),
		.spd_filt_i(spd_filt), .tors_level_i(tors), .rem_code_i(rem), .pid_fuel_i(pid_fuel),
		.max_fuel_i(max_fuel), .start_fuel_i(start_fuel), .speed_ref_o(sref), .speed_sel_o(ssel),
		.speed_err_o(serr), .fuel_demand_o(fuel), .alternate_gain_set_select_o(alt),
		.alarm_reset_pulse_o(arp), .sensor_fail_o(sfail), .remote_fail_o(rfail),
		.tors_limit_o(tlim), .remote_sel_o(rsel));

	task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		adr <= a;
		wdat <= d;
		wr <= 1'b1;
		do @(posedge sys_clk); while (wait_req !== 1'b0);
		wr <= 1'b0;
	endtask

	task automatic bus_rd(input logic [5:0] a);
		@(posedge sys_clk);
		adr <= a;
		rd <= 1'b1;
		do @(posedge sys_clk); while (wait_req !== 1'b0);
		rv = rdat;
		rd <= 1'b0;
	endtask

	task automatic wait_ref(input logic [15:0] t);
		n = 0;
		while (sref !== t && n < 20 * TC) begin
			@(posedge sys_clk);
			n++;
		end
	endtask

	task automatic wait_pulse;
		n = 0;
		while (arp !== 1'b1 && n < 12) begin
			@(posedge sys_clk);
			n++;
		end
		`CHK("alarm pulse", 1'b1, arp)
		repeat (2) @(posedge sys_clk);
	endtask

	task automatic t_power;
		int seen;
		seen = 0;
		@(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (6) begin
			@(posedge sys_clk);
			if (arp === 1'b1) seen++;
		end
		`CHK("power-up pulses", 1, seen)
		`CHK("ref at idle", RST_IDLE, sref)
		bus_rd(OFF_IDLE);
		`CHK("idle reg", {16'h0000, RST_IDLE}, rv)
		bus_rd(OFF_RATED);
		`CHK("rated reg", {16'h0000, RST_RATED}, rv)
		bus_wr(6'h3c, 32'h00001234);
		bus_rd(6'h3c);
		`CHK("unmapped", 32'h00000000, rv)
	endtask

	task automatic t_select;
		far.set_spd(16'd1300, 16'd1200);
		repeat (4) @(posedge sys_clk);
		`CHK("high select a", 16'd1300, ssel)
		`CHK("speed error", -17'sd600, serr)
		`CHK("low select pid", 16'h1000, fuel)
		far.set_spd(16'd1000, 16'd1200);
		pid_fuel <= 16'h3000;
		repeat (4) @(posedge sys_clk);
		`CHK("high select b", 16'd1200, ssel)
		`CHK("low select max", 16'h2000, fuel)
		start_fuel <= 16'h0900;
		repeat (4) @(posedge sys_clk);
		`CHK("low select start", 16'h0900, fuel)
		start_fuel <= 16'h2710;
		pid_fuel <= 16'h1000;
	endtask

	task automatic t_fail;
		bus_wr(OFF_TORS_LIM, 32'h00000100);
		bus_wr(OFF_TORS_FUEL, 32'h00000800);
		bus_wr(OFF_CTRL, 32'h00000001);
		far.set_filt(16'h0600);
		far.set_tors(16'h0200);
		repeat (4) @(posedge sys_clk);
		`CHK("filtered select", 16'h0600, ssel)
		`CHK("tors flag", 1'b1, tlim)
		`CHK("tors fuel", 16'h0800, fuel)
		far.set_tors(16'h0000);
		far.set_spd(16'd50, 16'd1200);
		repeat (4) @(posedge sys_clk);
		`CHK("fail a", 2'b01, sfail)
		`CHK("fallback select", 16'd1200, ssel)
		far.set_spd(16'd50, 16'd40);
		repeat (4) @(posedge sys_clk);
		`CHK("fail both", 2'b11, sfail)
		`CHK("zero fuel", 16'h0000, fuel)
		far.set_ct(esr_contacts_t'(6'b000010));
		repeat (5) @(posedge sys_clk);
		`CHK("override fuel", 16'h2000, fuel)
		far.set_ct(esr_contacts_t'(6'b000000));
		far.set_spd(16'd1000, 16'd40);
		repeat (4) @(posedge sys_clk);
		`CHK("still latched", 2'b11, sfail)
		far.alarm_toggle();
		wait_pulse();
		`CHK("partial clear", 2'b10, sfail)
		far.set_spd(16'd1000, 16'd1200);
		far.alarm_toggle();
		wait_pulse();
		`CHK("full clear", 2'b00, sfail)
		`CHK("tors clear", 1'b0, tlim)
		bus_wr(OFF_CTRL, 32'h00000000);
	endtask

	task automatic t_contacts;
		far.set_ct(esr_contacts_t'(6'b000001));
		repeat (4) @(posedge sys_clk);
		`CHK("gain set two", 1'b1, alt)
		far.set_ct(esr_contacts_t'(6'b011000));
		repeat (4) @(posedge sys_clk);
		`CHK("gain set one", 1'b0, alt)
		`CHK("remote on", 1'b1, rsel)
		far.set_ct(esr_contacts_t'(6'b010000));
		repeat (4) @(posedge sys_clk);
		`CHK("remote off", 1'b0, rsel)
		far.set_ct(esr_contacts_t'(6'b000000));
	endtask

	task automatic t_ramp;
		bus_wr(OFF_IDLE, 32'h00000800);
		repeat (3) @(posedge sys_clk);
		`CHK("idle capped", 16'h0708, sref)
		bus_wr(OFF_IDLE, 32'h00000700);
		repeat (3) @(posedge sys_clk);
		`CHK("idle moved", 16'h0700, sref)
		bus_wr(OFF_ACCEL_T, 32'h0000000a);
		bus_wr(OFF_DECEL_T, 32'h0000000a);
		far.set_ct(esr_contacts_t'(6'b100000));
		wait_ref(16'h0708);
		`CHK("accel time", 1'b1, (n >= 8 * TC && n <= 12 * TC))
		far.set_ct(esr_contacts_t'(6'b000000));
		wait_ref(16'h0700);
		`CHK("decel time", 1'b1, (n >= 8 * TC && n <= 12 * TC))
		far.set_ct(esr_contacts_t'(6'b100000));
		repeat (3 * TC) @(posedge sys_clk);
		far.set_ct(esr_contacts_t'(6'b110000));
		repeat (6) @(posedge sys_clk);
		bus_rd(OFF_STATUS);
		`CHK("accel aborted", 1'b1, (rv[9:8] !== 2'd1))
		bus_wr(OFF_RAISE_LIM, 32'h00000710);
		repeat (24 * TC) @(posedge sys_clk);
		`CHK("raise clamp", 16'h0710, sref)
		bus_wr(OFF_LOWER_LIM, 32'h00000704);
		far.set_ct(esr_contacts_t'(6'b101000));
		repeat (24 * TC) @(posedge sys_clk);
		`CHK("lower clamp", 16'h0704, sref)
	endtask

	task automatic t_remote;
		bus_wr(OFF_REM_LO, 32'h00000700);
		bus_wr(OFF_REM_HI, 32'h00000710);
		far.set_ct(esr_contacts_t'(6'b111000));
		repeat (24 * TC) @(posedge sys_clk);
		`CHK("remote mid", 16'h0708, sref)
		bus_wr(OFF_REM_LO, 32'h00000710);
		bus_wr(OFF_REM_HI, 32'h00000700);
		far.set_rem(16'h1000);
		repeat (24 * TC) @(posedge sys_clk);
		`CHK("remote reverse", 16'h0710, sref)
		far.set_rem(16'h5000);
		repeat (24 * TC) @(posedge sys_clk);
		`CHK("remote clamp", 16'h0704, sref)
		far.set_rem(16'h1000);
		repeat (24 * TC) @(posedge sys_clk);
		far.set_rem(16'h0400);
		repeat (24 * TC) @(posedge sys_clk);
		`CHK("remote fail", 1'b1, rfail)
		`CHK("fail ref", 16'h0704, sref)
		far.set_ct(esr_contacts_t'(6'b000000));
	endtask

	task automatic complete_run;
		if (num_errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		t_power();
		t_select();
		t_fail();
		t_contacts();
		t_ramp();
		t_remote();
		complete_run();
	end

	// The scenarios need well under ten thousand cycles.
	initial begin
		repeat (40000) @(posedge sys_clk);
		num_errors++;
		complete_run();
	end
endmodule // esr_seq_bench
